//--- verilog/ocm_pkg.sv
// Package with constants, types and helpers of the operating mode clock control.
`default_nettype none
package ocm_pkg;

    // Clock rates and oscillator start-up figures.
    localparam int HCLK_HZ           = 125_000_000;
    localparam int FAST_OSC_HZ       = 8_000_000;
    localparam int SLOW_OSC_HZ       = 32_000;
    localparam int FAST_TICK_CYCLES  = HCLK_HZ / FAST_OSC_HZ;
    localparam int SLOW_TICK_CYCLES  = HCLK_HZ / SLOW_OSC_HZ;
    localparam int SLOW_STABLE_TICKS = 2;
    localparam int FAST_STABLE_TICKS = 16;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CLK_MODE = 8'h00;
    localparam logic [7:0] ADDR_AUX_MODE = 8'h04;
    localparam logic [7:0] ADDR_STATUS   = 8'h08;
    localparam logic [7:0] ADDR_UNMAPPED = 8'hFF;

    // Reset values.
    localparam logic [7:0] CLK_MODE_RESET = 8'h03;
    localparam logic [7:0] AUX_MODE_RESET = 8'h00;

    // Field positions of the clock mode register.
    localparam int CM_DIV_LSB  = 5;
    localparam int CM_DIV_MSB  = 7;
    localparam int CM_SLOW_RDY = 3;
    localparam int CM_FAST_RDY = 2;
    localparam int CM_IDLE_EN  = 1;
    localparam int CM_FAST_SEL = 0;

    // Field positions of the auxiliary mode register.
    localparam int AUX_KEEP_ON = 7;
    localparam int AUX_RSV3    = 3;
    localparam int AUX_LOW_VOLTAGE_RESET_FLAG    = 2;
    localparam int AUX_WRF     = 0;

    // Operating modes.
    typedef enum logic [2:0] {
        OCM_NORMAL = 3'h0,
        OCM_SLOW   = 3'h1,
        OCM_IDLE0  = 3'h2,
        OCM_IDLE1  = 3'h3,
        OCM_SLEEP0 = 3'h4,
        OCM_SLEEP1 = 3'h5
    } ocm_mode_t;

    // System clock source: slow oscillator, or fast divided by 2**div_log.
    typedef struct packed {
        logic       slow;
        logic [2:0] div_log;
    } ocm_src_t;

    // Captured AHB address phase.
    typedef struct packed {
        logic       sel;
        logic       write;
        logic [7:0] addr;
    } ocm_ahb_req_t;

    // Decodes the select bit and divider field into a clock source.
    function automatic ocm_src_t ocm_decode(input logic       fast_sel,
                                            input logic [2:0] div_sel);
        ocm_src_t s;
        s.slow    = 1'b0;
        s.div_log = 3'h0;
        if (!fast_sel) begin
            if (div_sel < 3'h2) begin
                s.slow = 1'b1;
            end else begin
                s.div_log = 3'(4'h8 - {1'b0, div_sel});
            end
        end
        return s;
    endfunction

endpackage
`default_nettype wire

//--- verilog/ocm_osc_ready.sv
// Oscillator ready flag that rises after a number of stable oscillator ticks.
`default_nettype none
module ocm_osc_ready #(
    parameter int STABLE_TICKS = 2,
    parameter int CW           = 5
) (
    // Clock and reset.
    input  wire logic hclk,
    input  wire logic hresetn,
    // Oscillator state.
    input  wire logic osc_on,
    input  wire logic tick,
    // Ready flag.
    output var  logic ready
);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic          next_ready;

    // Ready drops while the oscillator is off and counts up again on restart.
    always_comb begin
        next_cnt   = cnt;
        next_ready = ready;
        if (!osc_on) begin
            next_cnt   = '0;
            next_ready = 1'b0;
        end else if (tick && !ready) begin
            if (cnt == CW'(STABLE_TICKS - 1)) begin
                next_ready = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt   <= '0;
            ready <= 1'b0;
        end else begin
            cnt   <= next_cnt;
            ready <= next_ready;
        end
    end

endmodule // ocm_osc_ready
`default_nettype wire

//--- verilog/ocm_clk_sel.sv
// Glitch-free system clock source selector and fast clock divider.
`default_nettype none
module ocm_clk_sel (
    // Clock and reset.
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Oscillator ticks and readiness.
    input  wire logic             fast_tick,
    input  wire logic             slow_tick,
    input  wire logic             fast_ready,
    input  wire logic             slow_ready,
    // Requested source.
    input  wire ocm_pkg::ocm_src_t req,
    // Selected source and derived ticks.
    output var  ocm_pkg::ocm_src_t active,
    output var  logic             sys_tick,
    output var  logic             div16_tick,
    output var  logic             div64_tick
);

    logic [5:0]        cnt;
    logic [5:0]        next_cnt;
    ocm_pkg::ocm_src_t next_active;
    logic              cur_tick;
    logic              do_switch;

    // Tick of a source: the slow tick, or a fast tick taken from the shared fast divide counter.
    function automatic logic src_tick(input ocm_pkg::ocm_src_t s,
                                      input logic [5:0]        c,
                                      input logic              ft,
                                      input logic              st);
        logic [5:0] mask;
        mask = 6'((7'h01 << s.div_log) - 7'h01);
        return s.slow ? st : (ft && ((c & mask) == mask));
    endfunction

    // A switch waits for the new source to be ready and for the end of a
    // whole period of the old one, so no pulse is cut short.
    always_comb begin
        cur_tick   = src_tick(active, cnt, fast_tick, slow_tick);
        do_switch  = (req != active) && cur_tick
                     && (req.slow ? slow_ready : fast_ready);
        sys_tick   = cur_tick && (active.slow ? slow_ready : fast_ready);
        div16_tick = fast_tick && (cnt[3:0] == 4'hF);
        div64_tick = fast_tick && (cnt == 6'h3F);
        next_active = do_switch ? req : active;
        next_cnt    = cnt;
        if (do_switch) begin
            next_cnt = 6'h00;
        end else if (fast_tick) begin
            next_cnt = cnt + 6'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt    <= 6'h00;
            active <= '{slow: 1'b0, div_log: 3'h0};
        end else begin
            cnt    <= next_cnt;
            active <= next_active;
        end
    end

endmodule // ocm_clk_sel
`default_nettype wire

//--- verilog/ocm_top.sv
// Operating mode and system clock control with an AHB-Lite register slave.
`default_nettype none
module ocm_top #(
    parameter int FAST_TICK_CYCLES  = ocm_pkg::FAST_TICK_CYCLES,
    parameter int SLOW_TICK_CYCLES  = ocm_pkg::SLOW_TICK_CYCLES,
    parameter int FAST_STABLE_TICKS = ocm_pkg::FAST_STABLE_TICKS,
    parameter int SLOW_STABLE_TICKS = ocm_pkg::SLOW_STABLE_TICKS
) (
    // Clock and reset.
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // CPU, watchdog and reset events.
    input  wire logic        halt_exec,
    input  wire logic        wake_event,
    input  wire logic        wdt_enable,
    input  wire logic        lvr_event,
    input  wire logic        wdt_soft_reset_event,
    // Clock enables and state.
    output var  logic        fast_osc_on,
    output var  logic        slow_osc_on,
    output var  logic        cpu_clk_en,
    output var  logic        periph_clk_en,
    output var  logic        fast_div16_en,
    output var  logic        fast_div64_en,
    output var  logic        tbc_clk_en,
    output var  logic        wdt_clk_en,
    output var  logic [2:0]  op_mode
);

    localparam int FW = $clog2(FAST_TICK_CYCLES + 1);
    localparam int SW = $clog2(SLOW_TICK_CYCLES + 1);
    logic [FW-1:0]        fast_cnt, next_fast_cnt;
    logic [SW-1:0]        slow_cnt, next_slow_cnt;
    logic                 fast_tick, next_fast_tick;
    logic                 slow_tick, next_slow_tick;
    logic                 next_fast_osc_on, next_slow_osc_on;
    logic                 fast_ready, slow_ready;
    ocm_pkg::ocm_mode_t   mode, next_mode, run_mode;
    ocm_pkg::ocm_src_t    req_src, active_src;
    logic                 sys_tick, div16_tick, div64_tick, run;
    ocm_pkg::ocm_ahb_req_t req, next_req;
    logic [2:0]           div_sel, next_div_sel;
    logic                 idle_on_halt_enable, next_idle_on_halt_enable;
    logic                 fast_slow_clock_select, next_fast_slow_clock_select;
    logic                 idle_sysclk_keep_on, next_idle_sysclk_keep_on;
    logic                 reserved_bit_three, next_reserved_bit_three;
    logic                 low_voltage_reset_flag, next_low_voltage_reset_flag;
    logic                 watchdog_ctrl_soft_reset_flag;
    logic                 next_watchdog_ctrl_soft_reset_flag;
    logic [31:0]          next_hrdata;
    logic [7:0]           rd_byte;
    logic                 wr_cm, wr_aux;
    logic                 next_cpu_clk_en, next_periph_clk_en;
    logic                 next_fast_div16_en, next_fast_div64_en;
    logic                 next_tbc_clk_en, next_wdt_clk_en;

    // Oscillator models: tick dividers run only while each oscillator is on.
    always_comb begin
        next_fast_cnt  = '0;
        next_slow_cnt  = '0;
        next_fast_tick = 1'b0;
        next_slow_tick = 1'b0;
        if (fast_osc_on) begin
            if (fast_cnt == FW'(FAST_TICK_CYCLES - 1)) begin
                next_fast_tick = 1'b1;
            end else begin
                next_fast_cnt = fast_cnt + 1'b1;
            end
        end
        if (slow_osc_on) begin
            if (slow_cnt == SW'(SLOW_TICK_CYCLES - 1)) begin
                next_slow_tick = 1'b1;
            end else begin
                next_slow_cnt = slow_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fast_cnt  <= '0;
            slow_cnt  <= '0;
            fast_tick <= 1'b0;
            slow_tick <= 1'b0;
        end else begin
            fast_cnt  <= next_fast_cnt;
            slow_cnt  <= next_slow_cnt;
            fast_tick <= next_fast_tick;
            slow_tick <= next_slow_tick;
        end
    end

    ocm_osc_ready #(
        .STABLE_TICKS (FAST_STABLE_TICKS),
        .CW           (8)
    ) u_fast_ready (
        .hclk    (hclk),
        .hresetn (hresetn),
        .osc_on  (fast_osc_on),
        .tick    (fast_tick),
        .ready   (fast_ready)
    );
    ocm_osc_ready #(
        .STABLE_TICKS (SLOW_STABLE_TICKS),
        .CW           (8)
    ) u_slow_ready (
        .hclk    (hclk),
        .hresetn (hresetn),
        .osc_on  (slow_osc_on),
        .tick    (slow_tick),
        .ready   (slow_ready)
    );
    ocm_clk_sel u_clk_sel (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .fast_tick  (fast_tick),
        .slow_tick  (slow_tick),
        .fast_ready (fast_ready),
        .slow_ready (slow_ready),
        .req        (req_src),
        .active     (active_src),
        .sys_tick   (sys_tick),
        .div16_tick (div16_tick),
        .div64_tick (div64_tick)
    );

    // Mode sequencing on halt and wake-up.
    always_comb begin
        req_src = ocm_pkg::ocm_decode(fast_slow_clock_select,
                                      div_sel);
        run = (mode == ocm_pkg::OCM_NORMAL) || (mode == ocm_pkg::OCM_SLOW);
        run_mode = active_src.slow ? ocm_pkg::OCM_SLOW : ocm_pkg::OCM_NORMAL;
        next_mode = mode;
        case (mode)
            ocm_pkg::OCM_NORMAL, ocm_pkg::OCM_SLOW: begin
                if (halt_exec) begin
                    if (idle_on_halt_enable) begin
                        next_mode = idle_sysclk_keep_on ? ocm_pkg::OCM_IDLE1
                                  : ocm_pkg::OCM_IDLE0;
                    end else begin
                        next_mode = wdt_enable ? ocm_pkg::OCM_SLEEP1
                                  : ocm_pkg::OCM_SLEEP0;
                    end
                end else begin
                    next_mode = run_mode;
                end
            end
            ocm_pkg::OCM_IDLE0, ocm_pkg::OCM_IDLE1,
            ocm_pkg::OCM_SLEEP0, ocm_pkg::OCM_SLEEP1: begin
                if (wake_event) begin
                    next_mode = run_mode;
                end
            end
            default: begin
                next_mode = ocm_pkg::OCM_NORMAL;
            end
        endcase
        // Fast stays on only while running or idle1 and still in use.
        next_fast_osc_on = (run || (mode == ocm_pkg::OCM_IDLE1))
                           && (!req_src.slow || !active_src.slow);
        next_slow_osc_on = !((mode == ocm_pkg::OCM_SLEEP0)
                           || ((mode == ocm_pkg::OCM_SLEEP1)
                               && !wdt_enable));
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode        <= ocm_pkg::OCM_NORMAL;
            fast_osc_on <= 1'b1;
            slow_osc_on <= 1'b1;
        end else begin
            mode        <= next_mode;
            fast_osc_on <= next_fast_osc_on;
            slow_osc_on <= next_slow_osc_on;
        end
    end

    // AHB-Lite register slave with zero wait states.
    always_comb begin
        next_req.sel   = hsel && hready && htrans[1];
        next_req.write = hwrite;
        next_req.addr  = (haddr[31:8] == 24'h000000) ? haddr[7:0]
                       : ocm_pkg::ADDR_UNMAPPED;
        case (next_req.addr)
            ocm_pkg::ADDR_CLK_MODE: begin
                rd_byte = {div_sel, 1'b0, slow_ready, fast_ready,
                           idle_on_halt_enable,
                           fast_slow_clock_select};
            end
            ocm_pkg::ADDR_AUX_MODE: begin
                rd_byte = {idle_sysclk_keep_on, 3'h0, reserved_bit_three,
                           low_voltage_reset_flag, 1'b0,
                           watchdog_ctrl_soft_reset_flag};
            end
            ocm_pkg::ADDR_STATUS: begin
                rd_byte = {5'h00, mode};
            end
            default: begin
                rd_byte = 8'h00;
            end
        endcase
        next_hrdata = hrdata;
        if (next_req.sel && !hwrite) begin
            next_hrdata = {24'h000000, rd_byte};
        end
        wr_cm  = req.sel && req.write && (req.addr == ocm_pkg::ADDR_CLK_MODE);
        wr_aux = req.sel && req.write && (req.addr == ocm_pkg::ADDR_AUX_MODE);
        next_div_sel                = div_sel;
        next_idle_on_halt_enable    = idle_on_halt_enable;
        next_fast_slow_clock_select = fast_slow_clock_select;
        next_idle_sysclk_keep_on    = idle_sysclk_keep_on;
        next_reserved_bit_three     = reserved_bit_three;
        if (wr_cm) begin
            next_div_sel = hwdata[ocm_pkg::CM_DIV_MSB:ocm_pkg::CM_DIV_LSB];
            next_idle_on_halt_enable    = hwdata[ocm_pkg::CM_IDLE_EN];
            next_fast_slow_clock_select = hwdata[ocm_pkg::CM_FAST_SEL];
        end
        if (wr_aux) begin
            next_idle_sysclk_keep_on = hwdata[ocm_pkg::AUX_KEEP_ON];
            next_reserved_bit_three  = hwdata[ocm_pkg::AUX_RSV3];
        end
        // Hardware set wins over a software clear in the same cycle.
        next_low_voltage_reset_flag = low_voltage_reset_flag;
        if (lvr_event) begin
            next_low_voltage_reset_flag = 1'b1;
        end else if (wr_aux && !hwdata[ocm_pkg::AUX_LOW_VOLTAGE_RESET_FLAG]) begin
            next_low_voltage_reset_flag = 1'b0;
        end
        next_watchdog_ctrl_soft_reset_flag = watchdog_ctrl_soft_reset_flag;
        if (wdt_soft_reset_event) begin
            next_watchdog_ctrl_soft_reset_flag = 1'b1;
        end else if (wr_aux && !hwdata[ocm_pkg::AUX_WRF]) begin
            next_watchdog_ctrl_soft_reset_flag = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req                    <= '{sel: 1'b0, write: 1'b0, addr: 8'h00};
            hrdata                 <= 32'h00000000;
            hreadyout              <= 1'b1;
            hresp                  <= 1'b0;
            div_sel                <= ocm_pkg::CLK_MODE_RESET[
                                      ocm_pkg::CM_DIV_MSB:ocm_pkg::CM_DIV_LSB];
            idle_on_halt_enable    <= ocm_pkg::CLK_MODE_RESET[
                                      ocm_pkg::CM_IDLE_EN];
            fast_slow_clock_select <= ocm_pkg::CLK_MODE_RESET[
                                      ocm_pkg::CM_FAST_SEL];
            idle_sysclk_keep_on    <= ocm_pkg::AUX_MODE_RESET[
                                      ocm_pkg::AUX_KEEP_ON];
            reserved_bit_three     <= ocm_pkg::AUX_MODE_RESET[
                                      ocm_pkg::AUX_RSV3];
            low_voltage_reset_flag <= ocm_pkg::AUX_MODE_RESET[
                                      ocm_pkg::AUX_LOW_VOLTAGE_RESET_FLAG];
            watchdog_ctrl_soft_reset_flag <= ocm_pkg::AUX_MODE_RESET[
                                             ocm_pkg::AUX_WRF];
        end else begin
            req                    <= next_req;
            hrdata                 <= next_hrdata;
            hreadyout              <= 1'b1;
            hresp                  <= 1'b0;
            div_sel                <= next_div_sel;
            idle_on_halt_enable    <= next_idle_on_halt_enable;
            fast_slow_clock_select <= next_fast_slow_clock_select;
            idle_sysclk_keep_on    <= next_idle_sysclk_keep_on;
            reserved_bit_three     <= next_reserved_bit_three;
            low_voltage_reset_flag <= next_low_voltage_reset_flag;
            watchdog_ctrl_soft_reset_flag
                                   <= next_watchdog_ctrl_soft_reset_flag;
        end
    end

    // Registered clock enables for the CPU and peripherals.
    always_comb begin
        next_cpu_clk_en    = run && sys_tick;
        next_periph_clk_en = (run || (mode == ocm_pkg::OCM_IDLE1))
                             && sys_tick;
        next_fast_div16_en = fast_osc_on && div16_tick;
        next_fast_div64_en = fast_osc_on && div64_tick;
        next_tbc_clk_en    = slow_tick && (mode != ocm_pkg::OCM_SLEEP0)
                             && (mode != ocm_pkg::OCM_SLEEP1);
        next_wdt_clk_en    = slow_tick && slow_osc_on;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cpu_clk_en    <= 1'b0;
            periph_clk_en <= 1'b0;
            fast_div16_en <= 1'b0;
            fast_div64_en <= 1'b0;
            tbc_clk_en    <= 1'b0;
            wdt_clk_en    <= 1'b0;
            op_mode       <= 3'h0;
        end else begin
            cpu_clk_en    <= next_cpu_clk_en;
            periph_clk_en <= next_periph_clk_en;
            fast_div16_en <= next_fast_div16_en;
            fast_div64_en <= next_fast_div64_en;
            tbc_clk_en    <= next_tbc_clk_en;
            wdt_clk_en    <= next_wdt_clk_en;
            op_mode       <= next_mode;
        end
    end

endmodule // ocm_top
`default_nettype wire

//--- sim/ocm_top_assertions.sv
// Checker of operating modes and clock enables at the top ports.
`default_nettype none
module ocm_chk (
    // Clock, reset and events.
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       halt_exec,
    input wire logic       wake_event,
    input wire logic       wdt_enable,
    // Observed outputs.
    input wire logic [2:0] op_mode,
    input wire logic       cpu_clk_en,
    input wire logic       periph_clk_en,
    input wire logic       fast_osc_on,
    input wire logic       slow_osc_on,
    input wire logic       wdt_clk_en,
    input wire logic       fast_div16_en,
    input wire logic       fast_div64_en,
    input wire logic       tbc_clk_en,
    input wire logic       hresp
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_halt; halt_exec && op_mode <= 3'h1; endsequence
    sequence s_slow_in; $rose(op_mode == 3'h1); endsequence
    a_halt_stops: assert property (s_halt |=> op_mode >= 3'h2)
        else $error("Halt left the run modes too late.");
    a_halt_ignored: assert property (halt_exec && !wake_event
        && op_mode >= 3'h2 |=> $stable(op_mode)) else $error("Halt not ignored.");
    a_sleep_depth: assert property (s_halt ##1 op_mode >= 3'h4
        |-> op_mode == ($past(wdt_enable) ? 3'h5 : 3'h4))
        else $error("Sleep depth does not follow watchdog enable.");
    a_cpu_halted: assert property ((op_mode >= 3'h2)[*3] |-> !cpu_clk_en)
        else $error("CPU clock runs while halted.");
    a_sleep0_off: assert property ((op_mode == 3'h4)[*4]
        |-> !slow_osc_on && !wdt_clk_en) else $error("Slow clock on in deep sleep.");
    a_sleep1_wdt: assert property ((op_mode == 3'h5 && wdt_enable)[*4]
        |-> slow_osc_on) else $error("Slow clock off in light sleep.");
    a_idle0_stop: assert property ((op_mode == 3'h2)[*4]
        |-> !periph_clk_en && !fast_osc_on && slow_osc_on)
        else $error("Idle without keep-on has wrong clocks.");
    a_idle1_on: assert property ((op_mode == 3'h3)[*4] |-> slow_osc_on)
        else $error("Slow clock off in idle with keep-on.");
    a_slow_fast_off: assert property (s_slow_in |-> ##[0:4] !fast_osc_on)
        else $error("Fast oscillator still on in slow mode.");
    a_div_stop: assert property ((!fast_osc_on)[*2]
        |-> !fast_div16_en && !fast_div64_en) else $error("Fast divider ticks.");
    a_tbc_sleep_off: assert property ((op_mode >= 3'h4)[*2]
        |-> !tbc_clk_en) else $error("Time base clock runs in sleep.");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("Bus response is not OKAY.");
endmodule // ocm_chk
bind ocm_top ocm_chk u_chk (.*);
`default_nettype wire

//--- sim/testbench.sv
// Self-checking testbench of the operating mode clock control.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] CM = ocm_pkg::ADDR_CLK_MODE;
    localparam logic [7:0] AX = ocm_pkg::ADDR_AUX_MODE;
    logic        hclk, hresetn, hsel, hwrite, halt_exec, wake_event;
    logic        wdt_enable, lvr_event, wdt_soft_reset_event, hreadyout;
    logic        hresp, fast_osc_on, slow_osc_on, cpu_clk_en, tbc_clk_en;
    logic        periph_clk_en, fast_div16_en, fast_div64_en, wdt_clk_en;
    logic [1:0]  htrans;
    logic [2:0]  hsize, op_mode;
    logic [31:0] haddr, hwdata, hrdata, r;
    int          n_mismatch = 0, cmp_count = 0, n, m;
    ocm_top #(.FAST_TICK_CYCLES(2), .SLOW_TICK_CYCLES(20),
        .FAST_STABLE_TICKS(2), .SLOW_STABLE_TICKS(2)) dut (.*, .hready(hreadyout));
    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end
    task automatic print_verdict();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic till(input bit pick);
        for (n = 0; n < 999; n++) begin
            @(posedge hclk);
            if ((pick ? cpu_clk_en : hreadyout) === 1'b1) break;
        end
        if (n == 999) n_mismatch++;
        if (n == 999) print_verdict();
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        till(0);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        till(0);
        r = hrdata;
    endtask
    task automatic ev(input logic h, input logic [2:0] e);
        halt_exec  <= h;
        wake_event <= !h;
        @(posedge hclk);
        halt_exec  <= 1'b0;
        wake_event <= 1'b0;
        repeat (2) @(posedge hclk);
        chk(op_mode, e);
    endtask
    task automatic t_regs();
        bus(0, CM, 0);
        chk(r & 32'hFB, 32'h03);
        bus(0, AX, 0);
        chk(r, 32'h00);
        repeat (60) @(posedge hclk);
        bus(1, CM, 8'h1F);
        bus(0, CM, 0);
        chk(r, 32'h0F);
        bus(1, AX, 8'hFF);
        bus(0, AX, 0);
        chk(r, 32'h88);
        bus(1, 8'h0C, 8'hFF);
        bus(0, 8'h0C, 0);
        chk(r, 32'h00);
    endtask
    task automatic t_flags();
        lvr_event            <= 1'b1;
        wdt_soft_reset_event <= 1'b1;
        @(posedge hclk);
        lvr_event            <= 1'b0;
        wdt_soft_reset_event <= 1'b0;
        bus(0, AX, 0);
        chk(r, 32'h8D);
        bus(1, AX, 8'h00);
        bus(0, AX, 0);
        chk(r, 32'h00);
    endtask
    task automatic t_div();
        for (int c = 1; c < 8; c++) begin
            bus(1, CM, c == 1 ? 8'h03 : {c[2:0], 5'h02});
            repeat (300) @(posedge hclk);
            till(1);
            till(1);
            chk(n + 1, c == 1 ? 2 : 2 << (8 - c));
        end
    endtask
    task automatic t_slow();
        bus(1, CM, 8'h22);
        repeat (300) @(posedge hclk);
        chk(op_mode, 3'h1);
        chk(fast_osc_on, 1'b0);
        till(1);
        till(1);
        chk(n + 1, 20);
        bus(1, CM, 8'h03);
        for (int k = 0; k < 99 && r[2] !== 1'b1; k++) bus(0, CM, 0);
        chk(r[2], 1'b1);
        repeat (60) @(posedge hclk);
        chk({fast_osc_on, op_mode}, 4'h8);
    endtask
    task automatic t_modes();
        ev(1, 3'h2);
        repeat (10) @(posedge hclk);
        ev(1, 3'h2);
        ev(0, 3'h0);
        bus(1, AX, 8'h80);
        ev(1, 3'h3);
        repeat (8) @(posedge hclk);
        n = 0;
        m = 0;
        repeat (128) @(posedge hclk) begin
            n += periph_clk_en;
            m += 8 * fast_div16_en + fast_div64_en;
        end
        chk(n, 64);
        chk(m, 33);
        ev(0, 3'h0);
        bus(1, CM, 8'h01);
        wdt_enable <= 1'b1;
        ev(1, 3'h5);
        repeat (10) @(posedge hclk);
        ev(0, 3'h0);
        wdt_enable <= 1'b0;
        ev(1, 3'h4);
        repeat (10) @(posedge hclk);
        bus(0, CM, 0);
        chk(r[3], 1'b0);
        bus(0, ocm_pkg::ADDR_STATUS, 0);
        chk(r, 32'h04);
        ev(0, 3'h0);
        repeat (100) @(posedge hclk);
        bus(0, CM, 0);
        chk(r[3], 1'b1);
    endtask
    initial begin
        {hresetn, hsel, hwrite, halt_exec, wake_event, wdt_enable} = 6'h00;
        {lvr_event, wdt_soft_reset_event, htrans, haddr, hwdata} = 68'h0;
        hsize = 3'h2;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_flags();
        t_div();
        t_slow();
        t_modes();
        print_verdict();
    end
endmodule // testbench
`default_nettype wire
